// ---- rtl/fsq_sequencer.sv ----
// Notes on behaviour
// - program memory written in four-byte units
// - unused data bytes ignored per space
// - segment picks program memory or data flash
// - data flash runs in background, busy flag
// - keys 0xFA then 0xF5 unlock
// - wrong second key discards first key
// - requests refused while any busy flag
// - cpu halted during program memory erase
// - cpu halted during program memory programming
// - data flash reads invalid while busy
// - data flash programmed one byte
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module fsq_sequencer
   import fsq_pkg::*;
#(
   parameter int ERASE_CNT = ERASE_CYCLES,
   parameter int PM_PROG_CNT = PM_PROG_CYCLES,
   parameter int DF_PROG_CNT = DF_PROG_CYCLES
)
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // cpu side
   output logic CPU_HALT,
   output logic DF_READ_VALID,
   // flash array side
   output logic FL_START,
   output logic [1:0] FL_OP,
   output logic FL_DF_SEL,
   output logic [7:0] FL_SEG,
   output logic [15:0] FL_ADDR,
   output logic [31:0] FL_WDATA
);
   // ****************************************
   // bus slave
   // ****************************************
   logic ack_q;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic req;
   logic wr;
   logic hit_seg, hit_addr, hit_d0, hit_d1, hit_key, hit_ctrl, hit_self, hit_state;

   // request held by master, answered one cycle later
   assign req = WB_CYC_I && WB_STB_I;
   assign wr = req && WB_WE_I && ack_q;
   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdat_q;

   // address decode
   assign hit_seg = (WB_ADR_I == OFS_SEG);
   assign hit_addr = (WB_ADR_I == OFS_ADDR);
   assign hit_d0 = (WB_ADR_I == OFS_DATA0);
   assign hit_d1 = (WB_ADR_I == OFS_DATA1);
   assign hit_key = (WB_ADR_I == OFS_KEY);
   assign hit_ctrl = (WB_ADR_I == OFS_CTRL);
   assign hit_self = (WB_ADR_I == OFS_SELF);
   assign hit_state = (WB_ADR_I == OFS_STATE);

   // ****************************************
   // software registers
   // ****************************************
   logic [7:0] seg_q, seg_d;
   logic [15:0] addr_q, addr_d, d0_q, d0_d, d1_q, d1_d;
   logic self_en_q, self_en_d;
   logic [1:0] ctrl_q, ctrl_d;
   logic key_first_q, key_first_d, unlocked_q, unlocked_d;
   logic wr_b0, wr_b1;

   // byte lane strobes
   assign wr_b0 = WB_SEL_I[0];
   assign wr_b1 = WB_SEL_I[1];

   // plain stores with byte lanes
   assign seg_d = (wr && hit_seg && wr_b0) ? WB_DAT_I[7:0] : seg_q;
   assign addr_d = (wr && hit_addr) ? {wr_b1 ? WB_DAT_I[15:8] : addr_q[15:8],
                                       wr_b0 ? WB_DAT_I[7:0] : addr_q[7:0]} : addr_q;
   assign d0_d = (wr && hit_d0) ? {wr_b1 ? WB_DAT_I[15:8] : d0_q[15:8],
                                   wr_b0 ? WB_DAT_I[7:0] : d0_q[7:0]} : d0_q;
   assign d1_d = (wr && hit_d1) ? {wr_b1 ? WB_DAT_I[15:8] : d1_q[15:8],
                                   wr_b0 ? WB_DAT_I[7:0] : d1_q[7:0]} : d1_q;
   assign self_en_d = (wr && hit_self && wr_b0) ? WB_DAT_I[SELF_EN_BIT] : self_en_q;

   // ****************************************
   // unlock key sequence
   // ****************************************
   logic key_wr, key_is_first, key_is_second, launch;

   assign key_wr = wr && hit_key && wr_b0;
   assign key_is_first = (WB_DAT_I[7:0] == KEY_FIRST);
   assign key_is_second = (WB_DAT_I[7:0] == KEY_SECOND);

   assign key_first_d = key_wr ? (key_is_first && !key_first_q) : key_first_q;
   // second key grants one operation, kept until a launch or until the self enable is cleared
   assign unlocked_d = (key_wr && key_first_q && key_is_second) ? 1'b1 :
                       ((launch || !self_en_q) ? 1'b0 : unlocked_q);

   // ****************************************
   // launch decode
   // ****************************************
   logic df_sel, busy_any, allowed;
   logic erase_req, pm_prog_req, df_prog_req, erase_done;
   logic [1:0] erase_bits;
   logic erase_go, prog_go;

   assign df_sel = (seg_q == DF_SEGMENT);
   assign allowed = unlocked_q && self_en_q && !busy_any;

   assign erase_bits = {WB_DAT_I[CTRL_SECTOR_BIT], WB_DAT_I[CTRL_BLOCK_BIT]};
   assign erase_req = wr && hit_ctrl && wr_b0 && (erase_bits != 2'b00);
   // program memory launched by second data write
   assign pm_prog_req = wr && hit_d1 && !df_sel;
   // data flash launched by lower data byte write
   assign df_prog_req = wr && hit_d0 && wr_b0 && df_sel;

   assign erase_go = erase_req && allowed;
   assign prog_go = (pm_prog_req || df_prog_req) && allowed;
   assign launch = erase_go || prog_go;

   // control bits stand while the erase runs
   assign ctrl_d = erase_go ? erase_bits : (erase_done ? 2'b00 : ctrl_q);

   // ****************************************
   // operation state and timer
   // ****************************************
   fsq_state_t state_q;
   fsq_state_t state_d;
   logic op_df_q;
   logic op_df_d;
   logic tmr_running;
   logic tmr_done;
   logic [TMR_W-1:0] tmr_cycles;
   logic [TMR_W-1:0] prog_cycles;

   assign prog_cycles = df_sel ? TMR_W'(DF_PROG_CNT) : TMR_W'(PM_PROG_CNT);
   assign tmr_cycles = erase_go ? TMR_W'(ERASE_CNT) : prog_cycles;
   assign erase_done = (state_q == ST_ERASE) && tmr_done;
   assign op_df_d = launch ? df_sel : op_df_q;

   // state transitions
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (erase_go)
               state_d = ST_ERASE;
            else if (prog_go)
               state_d = ST_PROG;
         end
         // busy ends when the count ends
         ST_ERASE, ST_PROG:
         begin
            if (tmr_done)
               state_d = ST_IDLE;
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   // duration counter
   fsq_op_timer u_timer (
      .clk(CORE_CLK),
      .rst_n(RSTN),
      .load(launch),
      .cycles(tmr_cycles),
      .running(tmr_running),
      .done(tmr_done)
   );

   logic erase_busy_flag;
   logic program_busy_flag;
   assign erase_busy_flag = (state_q == ST_ERASE);
   assign program_busy_flag = (state_q == ST_PROG);
   assign busy_any = erase_busy_flag || program_busy_flag || tmr_running;

   // ****************************************
   // array side capture
   // ****************************************
   logic start_q;
   logic [1:0] op_q;
   logic [1:0] op_d;
   logic [15:0] fl_addr_q;
   logic [15:0] fl_addr_d;
   logic [31:0] fl_wdata_q;
   logic [31:0] fl_wdata_d;
   logic [15:0] pm_addr;
   logic [31:0] pm_word;
   logic [31:0] df_word;

   assign pm_addr = {addr_q[15:PM_UNIT_LSBS], {PM_UNIT_LSBS{1'b0}}};
   // second data write lands this edge, so take it from the bus
   assign pm_word = {wr_b1 ? WB_DAT_I[15:8] : d1_q[15:8], wr_b0 ? WB_DAT_I[7:0] : d1_q[7:0], d0_q};
   // upper first byte and second word ignored
   assign df_word = {24'h000000, WB_DAT_I[7:0]};

   // operation code drops with the busy flags
   assign op_d = erase_go ? (erase_bits[0] ? OP_BLOCK_ERASE : OP_SECTOR_ERASE) :
                 (prog_go ? OP_PROG : (tmr_done ? OP_NONE : op_q));
   assign fl_addr_d = launch ? (df_sel ? addr_q : pm_addr) : fl_addr_q;
   assign fl_wdata_d = prog_go ? (df_sel ? df_word : pm_word) : fl_wdata_q;

   assign FL_START = start_q;
   assign FL_OP = op_q;
   assign FL_DF_SEL = op_df_q;
   assign FL_SEG = seg_q;
   assign FL_ADDR = fl_addr_q;
   assign FL_WDATA = fl_wdata_q;

   // ****************************************
   // cpu side status
   // ****************************************
   logic halt_q;
   logic halt_d;
   logic df_valid_q;
   logic df_valid_d;

   // program memory work halts the cpu
   // data flash work leaves the cpu running
   assign halt_d = launch ? !df_sel : (tmr_done ? 1'b0 : halt_q);
   // data flash reads blocked during its work
   assign df_valid_d = launch ? !df_sel : (tmr_done ? 1'b1 : df_valid_q);
   assign CPU_HALT = halt_q;
   assign DF_READ_VALID = df_valid_q;

   // ****************************************
   // read mux
   // ****************************************
   assign rdat_d = hit_seg ? {24'h000000, seg_q} :
                   hit_addr ? {16'h0000, addr_q} :
                   hit_d0 ? {16'h0000, d0_q} :
                   hit_d1 ? {16'h0000, d1_q} :
                   hit_ctrl ? {30'h00000000, ctrl_q} :
                   hit_self ? {31'h00000000, self_en_q} :
                   // completion seen on the busy flags
                   hit_state ? {30'h00000000, program_busy_flag, erase_busy_flag} :
                   32'h00000000;

   // bus handshake and read data
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
      end
      else
      begin
         ack_q <= req && !ack_q;
         rdat_q <= (req && !ack_q) ? rdat_d : rdat_q;
      end
   end

   // software registers
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         seg_q <= SEG_RESET;
         addr_q <= ADDR_RESET;
         d0_q <= DATA_RESET;
         d1_q <= DATA_RESET;
         self_en_q <= 1'b0;
         ctrl_q <= 2'b00;
         key_first_q <= 1'b0;
         unlocked_q <= 1'b0;
      end
      else
      begin
         seg_q <= seg_d;
         addr_q <= addr_d;
         d0_q <= d0_d;
         d1_q <= d1_d;
         self_en_q <= self_en_d;
         ctrl_q <= ctrl_d;
         key_first_q <= key_first_d;
         unlocked_q <= unlocked_d;
      end
   end

   // sequencer and array registers
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         state_q <= ST_IDLE;
         op_df_q <= 1'b0;
         start_q <= 1'b0;
         op_q <= OP_NONE;
         fl_addr_q <= ADDR_RESET;
         fl_wdata_q <= 32'h00000000;
         halt_q <= 1'b0;
         df_valid_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         op_df_q <= op_df_d;
         start_q <= launch;
         op_q <= op_d;
         fl_addr_q <= fl_addr_d;
         fl_wdata_q <= fl_wdata_d;
         halt_q <= halt_d;
         df_valid_q <= df_valid_d;
      end
   end
endmodule : fsq_sequencer
`default_nettype wire

// ---- rtl/fsq_pkg.sv ----
// ****************************************
// flash sequencer constants
// ****************************************
package fsq_pkg;
   // register word offsets (byte addresses)
   localparam logic [7:0] OFS_SEG = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_DATA0 = 8'h08;
   localparam logic [7:0] OFS_DATA1 = 8'h0c;
   localparam logic [7:0] OFS_KEY = 8'h10;
   localparam logic [7:0] OFS_CTRL = 8'h14;
   localparam logic [7:0] OFS_SELF = 8'h18;
   localparam logic [7:0] OFS_STATE = 8'h1c;
   // unlock keys
   localparam logic [7:0] KEY_FIRST = 8'hfa;
   localparam logic [7:0] KEY_SECOND = 8'hf5;
   // field positions
   localparam int CTRL_BLOCK_BIT = 0;
   localparam int CTRL_SECTOR_BIT = 1;
   localparam int SELF_EN_BIT = 0;
   localparam int STATE_ERASE_BIT = 0;
   localparam int STATE_PROG_BIT = 1;
   localparam int PM_UNIT_LSBS = 2;
   // segment value that selects the data flash
   localparam logic [7:0] DF_SEGMENT = 8'h0f;
   // reset values
   localparam logic [7:0] SEG_RESET = 8'h00;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   // timing, figures as printed
   localparam int CLK_MHZ = 250;
   localparam int ERASE_TIME_MS = 50;
   localparam int PM_PROG_TIME_US = 80;
   localparam int DF_PROG_TIME_US = 40;
   localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
   localparam int PM_PROG_CYCLES = PM_PROG_TIME_US * CLK_MHZ;
   localparam int DF_PROG_CYCLES = DF_PROG_TIME_US * CLK_MHZ;
   localparam int TMR_W = 24;
   // operation codes toward the array
   typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_BLOCK_ERASE, OP_SECTOR_ERASE} fsq_op_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} fsq_state_t;
endpackage : fsq_pkg

// ---- rtl/fsq_op_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// operation duration counter
// ****************************************
module fsq_op_timer
   import fsq_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic load,
   input wire logic [TMR_W-1:0] cycles,
   output logic running,
   output logic done
);
   logic [TMR_W-1:0] cnt_q;
   logic [TMR_W-1:0] cnt_d;
   logic run_q;
   logic run_d;
   logic last;

   // last cycle of a running count
   assign last = run_q && (cnt_q == {{(TMR_W-1){1'b0}}, 1'b1});
   assign cnt_d = load ? cycles : (run_q ? cnt_q - {{(TMR_W-1){1'b0}}, 1'b1} : cnt_q);
   assign run_d = load ? 1'b1 : (last ? 1'b0 : run_q);
   assign running = run_q;
   assign done = last;

   // count register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         run_q <= run_d;
      end
   end
endmodule : fsq_op_timer
`default_nettype wire

// ---- testbench/fsq_sequencer_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
// ********
// sequencer port checker
// ********
module fsq_sequencer_assertions
   import fsq_pkg::*;
#(
   parameter int ERASE_CNT = 20,
   parameter int PM_PROG_CNT = 8,
   parameter int DF_PROG_CNT = 5
)
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // bus
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   // cpu and array side
   input wire logic CPU_HALT,
   input wire logic DF_READ_VALID,
   input wire logic FL_START,
   input wire logic [1:0] FL_OP,
   input wire logic FL_DF_SEL,
   input wire logic [15:0] FL_ADDR,
   input wire logic [31:0] FL_WDATA
);
   int cnt_q;
   int exp_n;
   logic [1:0] op_q;
   logic df_q;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   // expected busy length of the running operation
   assign exp_n = (op_q == 2'h1) ? (df_q ? DF_PROG_CNT : PM_PROG_CNT) : ERASE_CNT;
   // count busy cycles from the start pulse
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         cnt_q <= 0;
         op_q <= 2'h0;
         df_q <= 1'b0;
      end
      else if (FL_START)
      begin
         cnt_q <= 1;
         op_q <= FL_OP;
         df_q <= FL_DF_SEL;
      end
      else if (|FL_OP)
         cnt_q <= cnt_q + 1;
   end
   ack_timing_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
   start_pulse_a: assert property (FL_START |=> !FL_START) else $error("start not a pulse");
   busy_refuse_a: assert property (FL_START |-> $past(FL_OP) == 2'h0) else $error("start while busy");
   pm_halt_a: assert property (|FL_OP && !FL_DF_SEL |-> CPU_HALT) else $error("cpu not halted");
   df_background_a: assert property (|FL_OP && FL_DF_SEL |-> !CPU_HALT && !DF_READ_VALID)
      else $error("data flash op state wrong");
   pm_align_a: assert property (FL_START && !FL_DF_SEL && FL_OP == 2'h1 |-> FL_ADDR[1:0] == 2'h0)
      else $error("unaligned program address");
   df_byte_a: assert property (FL_START && FL_DF_SEL && FL_OP == 2'h1 |-> FL_WDATA[31:8] == 24'h0)
      else $error("data flash write wider than a byte");
   busy_len_a: assert property ($fell(|FL_OP) |-> cnt_q == exp_n && !CPU_HALT && DF_READ_VALID)
      else $error("busy length wrong");
endmodule : fsq_sequencer_assertions
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// ********
// sequencer testbench
// ********
module tb_top
   import fsq_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] rd;
   wire logic [31:0] dat_o;
   wire logic ack, halt, rd_ok, st, dfs;
   wire logic [1:0] op;
   wire logic [15:0] fadr;
   wire logic [31:0] wdat;
   wire logic [7:0] fseg;
   int fail_count = 0;
   int total_checks = 0;
   int starts = 0;
   int s;
   int run_cyc = 0;
   localparam int HOST_CYC = 55 * 1000 * CLK_MHZ;
   fsq_sequencer #(.ERASE_CNT(20), .PM_PROG_CNT(8), .DF_PROG_CNT(5)) fsq_sequencer_inst (.CORE_CLK(clk),
      .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CPU_HALT(halt), .DF_READ_VALID(rd_ok),
      .FL_START(st), .FL_OP(op), .FL_DF_SEL(dfs), .FL_SEG(fseg), .FL_ADDR(fadr), .FL_WDATA(wdat));
   // clock, launch and run-time counters
   // core runs on its fast clock throughout
   always #2 clk = ~clk;
   always @(posedge clk) if (st === 1'b1) starts++;
   always @(posedge clk) if (rstn) run_cyc++;
   // ********
   // shared tasks
   // ********
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) fail_count++;
      if (g !== e) $display("BAD %s expected %h seen %h", nm, e, g);
   endtask : chk
   // one classic bus cycle, read data left in rd
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) fail_count++;
      if (ack !== 1'b1) end_sim();
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : xfer
   task keys(input logic [7:0] k1, input logic [7:0] k2);
      xfer(1'b1, OFS_KEY, {24'h0, k1});
      xfer(1'b1, OFS_KEY, {24'h0, k2});
   endtask : keys
   task launched(input logic [1:0] o, input logic df);
      @(posedge clk);
      chk("start", 32'h1, {31'h0, st});
      chk("op", {30'h0, o}, {30'h0, op});
      chk("df_sel", {31'h0, df}, {31'h0, dfs});
      chk("halt", {31'h0, !df}, {31'h0, halt});
      chk("read_valid", {31'h0, !df}, {31'h0, rd_ok});
   endtask : launched
   task automatic wait_idle;
      int n;
      n = 0;
      while (op !== 2'h0 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      if (op !== 2'h0) fail_count++;
      if (op !== 2'h0) end_sim();
      xfer(1'b0, OFS_STATE, 32'h0);
      chk("state idle", 32'h0, rd);
      chk("halt idle", 32'h0, {31'h0, halt});
   endtask : wait_idle
   // ********
   // scenarios
   // ********
   task t_reset;
      xfer(1'b0, OFS_STATE, 32'h0);
      chk("state reset", 32'h0, rd);
      xfer(1'b1, 8'h40, 32'h5);
      xfer(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rd);
   endtask : t_reset
   task t_pm;
      xfer(1'b1, OFS_SEG, 32'h1);
      xfer(1'b1, OFS_ADDR, 32'h1237);
      xfer(1'b1, OFS_DATA0, 32'habcd);
      xfer(1'b1, OFS_SELF, 32'h1);
      keys(KEY_FIRST, KEY_SECOND);
      xfer(1'b1, OFS_DATA1, 32'h1234);
      launched(2'h1, 1'b0);
      chk("pm seg", 32'h1, {24'h0, fseg});
      chk("pm addr", 32'h1234, {16'h0, fadr});
      chk("pm data", 32'h1234abcd, wdat);
      xfer(1'b0, OFS_STATE, 32'h0);
      chk("state prog", 32'h2, rd);
      wait_idle();
   endtask : t_pm
   task t_keys;
      s = starts;
      keys(KEY_FIRST, 8'h12);
      xfer(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
      xfer(1'b1, OFS_DATA1, 32'h1);
      keys(KEY_FIRST, KEY_FIRST);
      xfer(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
      xfer(1'b1, OFS_DATA1, 32'h1);
      chk("bad key starts", s, starts);
      xfer(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
      xfer(1'b1, OFS_SEG, 32'h1);
      xfer(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
      xfer(1'b1, OFS_DATA1, 32'h1);
      launched(2'h1, 1'b0);
      wait_idle();
   endtask : t_keys
   task t_df;
      xfer(1'b1, OFS_SEG, {24'h0, DF_SEGMENT});
      xfer(1'b1, OFS_ADDR, 32'h5);
      xfer(1'b1, OFS_SELF, 32'h1);
      keys(KEY_FIRST, KEY_SECOND);
      xfer(1'b1, OFS_DATA0, 32'hff5a);
      launched(2'h1, 1'b1);
      chk("df data", 32'h5a, wdat);
      chk("df addr", 32'h5, {16'h0, fadr});
      xfer(1'b0, OFS_STATE, 32'h0);
      chk("df busy", 32'h2, rd);
      wait_idle();
      chk("df readable", 32'h1, {31'h0, rd_ok});
      // software side disables further operations
      xfer(1'b1, OFS_SELF, 32'h0);
      s = starts;
      keys(KEY_FIRST, KEY_SECOND);
      xfer(1'b1, OFS_DATA0, 32'h11);
      chk("disabled starts", s, starts);
   endtask : t_df
   task t_erase(input logic [31:0] c, input logic [1:0] o, input logic df);
      xfer(1'b1, OFS_SEG, df ? {24'h0, DF_SEGMENT} : 32'h1);
      xfer(1'b1, OFS_SELF, 32'h1);
      keys(KEY_FIRST, KEY_SECOND);
      xfer(1'b1, OFS_CTRL, c);
      launched(o, df);
      xfer(1'b0, OFS_STATE, 32'h0);
      chk("erase busy", 32'h1, rd);
      s = starts;
      keys(KEY_FIRST, KEY_SECOND);
      xfer(1'b1, df ? OFS_DATA0 : OFS_DATA1, 32'h2);
      chk("busy starts", s, starts);
      wait_idle();
      chk("erase readable", 32'h1, {31'h0, rd_ok});
      xfer(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl cleared", 32'h0, rd);
      xfer(1'b1, OFS_SELF, 32'h0);
   endtask : t_erase
   // main sequence
   initial
   begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      // every area is erased ahead of its programming
      t_erase(32'h1, 2'h2, 1'b0);
      t_erase(32'h2, 2'h3, 1'b0);
      t_pm();
      t_keys();
      t_erase(32'h3, 2'h2, 1'b1);
      t_df();
      chk("host time", 32'h1, {31'h0, run_cyc < HOST_CYC});
      end_sim();
   end
endmodule : tb_top
bind fsq_sequencer fsq_sequencer_assertions #(.ERASE_CNT(ERASE_CNT), .PM_PROG_CNT(PM_PROG_CNT),
   .DF_PROG_CNT(DF_PROG_CNT)) chk_inst (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .CPU_HALT(CPU_HALT), .DF_READ_VALID(DF_READ_VALID),
   .FL_START(FL_START), .FL_OP(FL_OP), .FL_DF_SEL(FL_DF_SEL), .FL_ADDR(FL_ADDR), .FL_WDATA(FL_WDATA));
`default_nettype wire
